// File: dv/rfd_core_monitor.sv
// Port checker for the register file core
`default_nettype none
module rfd_core_monitor (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cmd_ready_ff,
    input wire logic [15:0] pmem_rdata,
    input wire logic [13:0] pmem_addr_ff,
    input wire logic [15:0] instr_ff,
    input wire logic instr_valid_ff,
    input wire logic io_re_ff,
    input wire logic [7:0] irq_req,
    input wire logic irq_ack_ff,
    input wire logic [2:0] irq_idx_ff,
    input wire logic flash_we_ff,
    input wire logic [13:0] flash_waddr_ff,
    input wire logic [1:0] boot_size_sel,
    input wire logic [1:0] app_lock
);
    timeunit 1ns;
    timeprecision 1ps;
    // First word of the boot section
    logic [13:0] boot_lo;
    assign boot_lo = ~((14'h0100 << boot_size_sel) - 14'h0001);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Two stalled push cycles
    sequence push_s;
        !cmd_ready_ff ##1 !cmd_ready_ff;
    endsequence
    chk_fetch_word: assert property (instr_valid_ff |-> instr_ff == $past(pmem_rdata))
        else $error("bad fetch word");
    chk_pc_step: assert property (instr_valid_ff |-> pmem_addr_ff == $past(pmem_addr_ff) + 14'h1)
        else $error("bad pc step");
    chk_vec_addr: assert property (irq_ack_ff |-> pmem_addr_ff == {10'h0, irq_idx_ff, 1'b0})
        else $error("bad vector");
    chk_irq_prio: assert property (irq_ack_ff |->
        ($past(irq_req, 2) & ((8'h02 << irq_idx_ff) - 8'h01)) == (8'h01 << irq_idx_ff))
        else $error("bad priority");
    chk_ack_push: assert property (irq_ack_ff |-> push_s ##1 !irq_ack_ff)
        else $error("bad push");
    chk_io_pulse: assert property (io_re_ff |=> !io_re_ff)
        else $error("io read too long");
    chk_io_wait: assert property (io_re_ff |-> !cmd_ready_ff)
        else $error("io read no stall");
    chk_spm_lock: assert property (flash_we_ff && flash_waddr_ff < boot_lo |-> !app_lock[0])
        else $error("locked write");
    chk_spm_pulse: assert property (flash_we_ff |=> !flash_we_ff)
        else $error("write too long");
endmodule
bind rfd_core rfd_core_monitor i_mon (.clk, .rst_n, .cmd_ready_ff, .pmem_rdata, .pmem_addr_ff,
    .instr_ff, .instr_valid_ff, .io_re_ff, .irq_req, .irq_ack_ff, .irq_idx_ff, .flash_we_ff,
    .flash_waddr_ff, .boot_size_sel, .app_lock);
`default_nettype wire

// File: dv/rfd_mem_model.sv
// Flash and peripheral model facing the core
`default_nettype none
module rfd_mem_model (
    input wire logic [13:0] pmem_addr_ff,
    input wire logic [5:0] io_addr_ff,
    input wire logic io_re_ff,
    output logic [15:0] pmem_rdata,
    output logic [7:0] io_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // Flash word: address byte high, its inverse low
    assign pmem_rdata = {pmem_addr_ff[7:0], ~pmem_addr_ff[7:0]};
    // Peripheral data valid only while strobed
    assign io_rdata = io_re_ff ? {2'b10, io_addr_ff} : {2'b01, ~io_addr_ff};
endmodule
`default_nettype wire

// File: dv/testbench.sv
// Self-checking bench for the register file core
`default_nettype none
module testbench;
    import rfd_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    // Results for 3C op 0F, and FE times 03
    localparam logic [7:0] AE [8] = '{8'h4B, 8'h2D, 8'h0C, 8'h3F, 8'h33, 8'h0F, 8'h3D, 8'h3B};
    localparam logic [15:0] ME [3] = '{16'h02FA, 16'hFFFA, 16'hFFF4};
    logic clk, rst_n, cmd_valid, cmd_src_imm, cmd_ready_ff, instr_valid_ff, io_we_ff, io_re_ff;
    logic flash_we_ff, irq_ack_ff;
    rfd_op_e cmd_op;
    rfd_alu_e cmd_alu;
    rfd_amode_e cmd_amode;
    rfd_ptr_e cmd_ptr;
    rfd_mul_e cmd_mul;
    logic [4:0] cmd_rd, cmd_rr;
    logic [7:0] cmd_imm, io_rdata, io_wdata_ff, irq_req;
    logic [5:0] cmd_disp, io_addr_ff;
    logic [15:0] cmd_addr, pmem_rdata, instr_ff, flash_wdata_ff;
    logic [13:0] pmem_addr_ff, flash_waddr_ff, pc_at;
    logic [1:0] app_lock;
    logic [2:0] irq_idx_ff;
    int n_mismatch, checks, cyc;
    rfd_core i_rfd_core (.clk, .rst_n, .cmd_valid, .cmd_op, .cmd_alu, .cmd_src_imm, .cmd_rd,
        .cmd_rr, .cmd_imm, .cmd_amode, .cmd_ptr, .cmd_disp, .cmd_addr, .cmd_mul, .pmem_rdata,
        .io_rdata, .irq_req, .boot_size_sel(2'b00), .app_lock, .boot_lock(2'b00), .cmd_ready_ff,
        .pmem_addr_ff, .instr_ff, .instr_valid_ff, .io_addr_ff, .io_wdata_ff, .io_we_ff,
        .io_re_ff, .flash_we_ff, .flash_waddr_ff, .flash_wdata_ff, .irq_ack_ff, .irq_idx_ff);
    rfd_mem_model i_mem (.pmem_addr_ff, .io_addr_ff, .io_re_ff, .pmem_rdata, .io_rdata);
    always #2.5 clk = ~clk;
    // Cycle ceiling against hangs
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_mismatch++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(logic [15:0] got, logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One command handshake; returns just after the taking edge
    task automatic go(rfd_op_e o);
        int n;
        n = 0;
        @(negedge clk);
        cmd_op = o;
        cmd_valid = 1'b1;
        while (cmd_ready_ff !== 1'b1 && n < 40)
        begin
            @(negedge clk);
            n++;
        end
        if (n == 40)
            n_mismatch++;
        pc_at = pmem_addr_ff;
        @(negedge clk);
        cmd_valid = 1'b0;
    endtask
    task automatic li(int r, int v);
        cmd_alu = ALU_MOV;
        cmd_src_imm = 1'b1;
        cmd_rd = 5'(r);
        cmd_imm = 8'(v);
        go(OP_ALU);
    endtask
    task automatic xs(rfd_op_e o, int r, rfd_amode_e m, logic [15:0] a);
        cmd_rd = 5'(r);
        cmd_amode = m;
        cmd_addr = a;
        go(o);
    endtask
    // Register contents seen through an I/O store
    task automatic peek(int r, logic [7:0] e);
        xs(OP_ST, r, AM_DIRECT, 16'h0020);
        chk({7'h0, io_we_ff, io_wdata_ff}, {8'h01, e});
    endtask
    task automatic t_alu();
        for (int k = 0; k < 8; k++)
        begin
            li(16, 8'h3C);
            li(17, 8'h0F);
            cmd_rd = 5'd16;
            cmd_alu = rfd_alu_e'(k);
            cmd_src_imm = 1'b0;
            cmd_rr = 5'd17;
            go(OP_ALU);
            peek(16, AE[k]);
        end
        li(2, 8'hFE);
        li(3, 8'h03);
        for (int k = 0; k < 3; k++)
        begin
            cmd_mul = rfd_mul_e'(k);
            cmd_rd = 5'd2;
            cmd_rr = 5'd3;
            cmd_src_imm = 1'b0;
            go(OP_MUL);
            peek(1, ME[k][15:8]);
            peek(0, ME[k][7:0]);
        end
    endtask
    task automatic t_data();
        li(16, 8'hA5);
        xs(OP_ST, 16, AM_DIRECT, 16'h085F);
        xs(OP_ST, 16, AM_DIRECT, 16'h0005);
        xs(OP_ST, 16, AM_DIRECT, 16'h0860);
        xs(OP_ST, 16, AM_DIRECT, 16'h00A0);
        xs(OP_LD, 20, AM_DIRECT, 16'h085F);
        peek(20, 8'hA5);
        peek(5, 8'hA5);
        xs(OP_LD, 21, AM_DIRECT, 16'h0860);
        peek(21, 8'h00);
        li(28, 8'h60);
        li(29, 8'h00);
        cmd_ptr = PTR_Y;
        cmd_disp = 6'h3F;
        li(16, 8'hA1);
        xs(OP_ST, 16, AM_POSTINC, 16'h0000);
        li(16, 8'hB2);
        xs(OP_ST, 16, AM_POSTINC, 16'h0000);
        xs(OP_LD, 20, AM_PREDEC, 16'h0000);
        peek(20, 8'hB2);
        peek(28, 8'h61);
        xs(OP_LD, 21, AM_DISP, 16'h0000);
        peek(21, 8'hA5);
        li(26, 8'h10);
        li(27, 8'h00);
        cmd_ptr = PTR_X;
        xs(OP_LD, 22, AM_IND, 16'h0000);
        peek(22, 8'hB2);
        xs(OP_LD, 20, AM_DIRECT, 16'h0025);
        peek(20, 8'h85);
        li(30, 8'h01);
        li(31, 8'h01);
        cmd_rd = 5'd20;
        go(OP_LPM);
        peek(20, 8'h80);
        li(30, 8'h00);
        cmd_rd = 5'd20;
        go(OP_LPM);
        peek(20, 8'h7F);
    endtask
    task automatic flash_self_write_instr(logic e);
        logic seen;
        seen = 1'b0;
        go(OP_SPM);
        repeat (3)
        begin
            seen |= flash_we_ff;
            if (flash_we_ff)
                chk({flash_waddr_ff, 2'b00}, 16'h0200);
            @(negedge clk);
        end
        chk({15'h0, seen}, {15'h0, e});
        chk(flash_wdata_ff, 16'hFFF4);
    endtask
    task automatic t_flow();
        logic [13:0] r;
        go(OP_IJMP);
        chk({2'b00, pmem_addr_ff}, 16'h0100);
        cmd_addr = 16'h3F00;
        go(OP_JMP);
        chk({2'b00, pmem_addr_ff}, 16'h3F00);
        go(OP_NOP);
        flash_self_write_instr(1'b1);
        app_lock = 2'b01;
        flash_self_write_instr(1'b0);
        app_lock = 2'b00;
        cmd_addr = 16'h0000;
        go(OP_JMP);
        go(OP_NOP);
        flash_self_write_instr(1'b0);
        li(16, 8'h5F);
        xs(OP_ST, 16, AM_DIRECT, 16'h005D);
        li(16, 8'h08);
        xs(OP_ST, 16, AM_DIRECT, 16'h005E);
        cmd_addr = 16'h0200;
        go(OP_CALL);
        r = pc_at;
        xs(OP_LD, 20, AM_DIRECT, 16'h085F);
        peek(20, r[7:0]);
        xs(OP_LD, 20, AM_DIRECT, 16'h085E);
        peek(20, {2'b00, r[13:8]});
        xs(OP_LD, 20, AM_DIRECT, 16'h005D);
        peek(20, 8'h5D);
        irq_req = 8'h06;
        go(OP_NOP);
        chk({15'h0, irq_ack_ff}, 16'h0000);
        li(16, 8'h80);
        xs(OP_ST, 16, AM_DIRECT, 16'h005F);
        repeat (10)
            if (irq_ack_ff !== 1'b1)
                @(negedge clk);
        chk({13'h0, irq_idx_ff}, 16'h0001);
        chk({2'b00, pmem_addr_ff}, 16'h0002);
        irq_req = 8'h00;
    endtask
    initial
    begin
        {clk, rst_n, cmd_valid, cmd_src_imm, cmd_rd, cmd_rr, cmd_imm} = '0;
        {cmd_disp, cmd_addr, irq_req, app_lock, n_mismatch, checks, cyc} = '0;
        cmd_op = OP_NOP;
        cmd_alu = ALU_ADD;
        cmd_amode = AM_DIRECT;
        cmd_ptr = PTR_X;
        cmd_mul = MUL_U;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        t_alu();
        t_data();
        t_flow();
        end_of_test();
    end
endmodule
`default_nettype wire

// File: hw/rfd_cfg.svh
// Constants for the register file and data-space decode block
`ifndef RFD_CFG_SVH
`define RFD_CFG_SVH
`define RFD_NREG 32
`define RFD_PTR_BASE 5'h1A
`define RFD_PTR_Z 5'h1E
`define RFD_IO_BASE 16'h0020
`define RFD_SRAM_BASE 16'h0060
`define RFD_SRAM_END 16'h085F
`define RFD_SRAM_DEPTH 2048
`define RFD_SRAM_AW 11
`define RFD_SPL_ADDR 16'h005D
`define RFD_SPH_ADDR 16'h005E
`define RFD_SREG_ADDR 16'h005F
`define RFD_SREG_GIE 7
`define RFD_SREG_Z 1
`define RFD_SREG_C 0
`define RFD_SREG_RST 8'h00
`define RFD_SP_RST 12'h000
`define RFD_PC_RST 14'h0000
`define RFD_PC_TOP 14'h3FFF
`define RFD_BOOT_MIN_WORDS 14'h0100
`define RFD_VEC_WORDS 14'h0002
`define RFD_NIRQ 8
`define RFD_LOCK_WR 0
`define RFD_LOCK_RD 1
`define RFD_LOCKED_BYTE 8'h00
`endif

// File: hw/rfd_core.sv
// Working-register file, data-space decode, fetch, stack and interrupt entry
`default_nettype none
`include "rfd_cfg.svh"
module rfd_core (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire rfd_pkg::rfd_op_e cmd_op,
    input wire rfd_pkg::rfd_alu_e cmd_alu,
    input wire logic cmd_src_imm,
    input wire logic [4:0] cmd_rd,
    input wire logic [4:0] cmd_rr,
    input wire logic [7:0] cmd_imm,
    input wire rfd_pkg::rfd_amode_e cmd_amode,
    input wire rfd_pkg::rfd_ptr_e cmd_ptr,
    input wire logic [5:0] cmd_disp,
    input wire logic [15:0] cmd_addr,
    input wire rfd_pkg::rfd_mul_e cmd_mul,
    input wire logic [15:0] pmem_rdata,
    input wire logic [7:0] io_rdata,
    input wire logic [`RFD_NIRQ-1:0] irq_req,
    input wire logic [1:0] boot_size_sel,
    input wire logic [1:0] app_lock,
    input wire logic [1:0] boot_lock,
    output logic cmd_ready_ff,
    output logic [13:0] pmem_addr_ff,
    output logic [15:0] instr_ff,
    output logic instr_valid_ff,
    output logic [5:0] io_addr_ff,
    output logic [7:0] io_wdata_ff,
    output logic io_we_ff,
    output logic io_re_ff,
    output logic flash_we_ff,
    output logic [13:0] flash_waddr_ff,
    output logic [15:0] flash_wdata_ff,
    output logic irq_ack_ff,
    output logic [2:0] irq_idx_ff
);
    import rfd_pkg::*;

    logic [7:0] rf_ff [`RFD_NREG]; // Working registers
    rfd_state_e state_ff, nxt_state;
    logic [7:0] sreg_ff; // Status: enable, zero, carry
    logic [11:0] sp_ff; // Stack pointer
    logic [13:0] instr_pc_ff; // Word address of instr_ff
    logic [13:0] ret_ff; // Return address being pushed
    logic [13:0] resume_ff; // Fetch address to restore after a flash load
    logic [4:0] ld_rd_ff; // Destination of a pending load
    logic ld_pend_ff; // Pending load wants a write-back
    logic ld_lsb_ff; // Byte select for the flash load
    logic ld_blk_ff; // Flash load blocked by lock
    rfd_region_e ld_src_ff; // Where the pending load reads
    logic [`RFD_NIRQ-1:0] irq_ff; // Registered requests
    logic take_cmd, take_irq, jump; // Cycle decisions
    logic [13:0] jump_tgt;
    logic [4:0] pidx; // Low register of the chosen pointer
    logic [15:0] ptr_val, ptr_new, ea; // Pointer, updated pointer, operand address
    logic ptr_we;
    rfd_region_e reg_kind;
    logic [7:0] opa, opb, din; // ALU operands, data read from the data space
    logic [8:0] alu_res;
    logic [15:0] prod;
    logic byte_we, pair_we;
    logic [4:0] byte_wa, pair_wa;
    logic [7:0] byte_wd;
    logic [15:0] pair_wd;
    logic sram_req, sram_we;
    logic [`RFD_SRAM_AW-1:0] sram_addr;
    logic [7:0] sram_wdata, sram_rdata;
    logic [13:0] boot_start, zword;
    logic from_boot, tgt_boot;
    logic [2:0] irq_sel;
    logic [15:0] sp_ext;

    // Data-space address decode
    function automatic rfd_region_e region(input logic [15:0] a);
        if (a < `RFD_IO_BASE)
            region = RG_REG;
        else if (a < `RFD_SRAM_BASE)
            region = RG_IO;
        else if (a <= `RFD_SRAM_END)
            region = RG_SRAM;
        else
            region = RG_NONE;
    endfunction

    assign take_cmd = (state_ff == S_EXEC) && cmd_ready_ff && cmd_valid;
    assign take_irq = (state_ff == S_EXEC) && !cmd_ready_ff && sreg_ff[`RFD_SREG_GIE]
                      && (|irq_ff);
    assign pidx = `RFD_PTR_BASE + {2'b00, cmd_ptr, 1'b0};
    assign ptr_val = {rf_ff[pidx + 5'h01], rf_ff[pidx]};
    assign zword = {rf_ff[`RFD_PTR_Z + 5'h01][6:0], rf_ff[`RFD_PTR_Z][7:1]};
    assign boot_start = `RFD_PC_TOP - ((`RFD_BOOT_MIN_WORDS << boot_size_sel) - 14'h0001);
    assign from_boot = instr_pc_ff >= boot_start;
    assign tgt_boot = zword >= boot_start;
    assign sp_ext = {4'h0, sp_ff};

    // Lowest pending index wins
    always_comb
    begin
        irq_sel = 3'd0;
        for (int i = `RFD_NIRQ - 1; i >= 0; i--)
        begin
            if (irq_ff[i])
                irq_sel = 3'(i);
        end
    end

    // Operand address for the five data modes
    always_comb
    begin
        ea = cmd_addr;
        ptr_new = ptr_val;
        ptr_we = 1'b0;
        case (cmd_amode)
            AM_DIRECT: ea = cmd_addr;
            AM_DISP: ea = ptr_val + {10'h000, cmd_disp};
            AM_IND: ea = ptr_val;
            AM_PREDEC:
            begin
                ptr_new = ptr_val - 16'h0001;
                ea = ptr_new;
                ptr_we = 1'b1;
            end
            AM_POSTINC:
            begin
                ptr_new = ptr_val + 16'h0001;
                ea = ptr_val;
                ptr_we = 1'b1;
            end
            default: ea = cmd_addr;
        endcase
        reg_kind = region(ea);
    end

    // ALU and multiplier
    always_comb
    begin
        opa = rf_ff[cmd_rd];
        opb = cmd_src_imm ? cmd_imm : rf_ff[cmd_rr];
        case (cmd_alu)
            ALU_ADD: alu_res = {1'b0, opa} + {1'b0, opb};
            ALU_SUB: alu_res = {1'b0, opa} - {1'b0, opb};
            ALU_AND: alu_res = {1'b0, opa & opb};
            ALU_OR: alu_res = {1'b0, opa | opb};
            ALU_EOR: alu_res = {1'b0, opa ^ opb};
            ALU_MOV: alu_res = {1'b0, opb};
            ALU_INC: alu_res = {1'b0, opa + 8'h01};
            default: alu_res = {1'b0, opa - 8'h01};
        endcase
        case (cmd_mul)
            MUL_U: prod = {8'h00, opa} * {8'h00, opb};
            MUL_S: prod = 16'($signed(opa) * $signed(opb));
            default: prod = 16'($signed(opa) * $signed(opb)) << 1;
        endcase
    end

    // Data read for loads that finish at once
    always_comb
    begin
        case (ea)
            `RFD_SPL_ADDR: din = sp_ff[7:0];
            `RFD_SPH_ADDR: din = {4'h0, sp_ff[11:8]};
            `RFD_SREG_ADDR: din = sreg_ff;
            default: din = (reg_kind == RG_REG) ? rf_ff[ea[4:0]] : 8'h00;
        endcase
    end

    // Register write ports: one byte port, one pair port
    always_comb
    begin
        byte_we = 1'b0;
        byte_wa = cmd_rd;
        byte_wd = alu_res[7:0];
        pair_we = 1'b0;
        pair_wa = pidx;
        pair_wd = ptr_new;
        if (take_cmd)
        begin
            case (cmd_op)
                OP_ALU: byte_we = 1'b1;
                OP_MUL:
                begin
                    pair_we = 1'b1;
                    pair_wa = 5'h00;
                    pair_wd = prod;
                end
                OP_LD:
                begin
                    byte_we = nxt_state == S_EXEC;
                    byte_wd = din;
                    pair_we = ptr_we && (cmd_amode != AM_DIRECT);
                end
                OP_ST:
                begin
                    byte_we = (reg_kind == RG_REG);
                    byte_wa = ea[4:0];
                    byte_wd = rf_ff[cmd_rd];
                    pair_we = ptr_we && (cmd_amode != AM_DIRECT);
                end
                default: byte_we = 1'b0;
            endcase
        end
        else if (ld_pend_ff && (state_ff == S_WAIT || state_ff == S_LPM) && (nxt_state == S_EXEC))
        begin
            byte_we = 1'b1;
            byte_wa = ld_rd_ff;
            if (state_ff == S_LPM)
                byte_wd = ld_blk_ff ? `RFD_LOCKED_BYTE
                          : (ld_lsb_ff ? pmem_rdata[15:8] : pmem_rdata[7:0]);
            else if (ld_src_ff == RG_SRAM)
                byte_wd = sram_rdata;
            else
                byte_wd = io_rdata;
        end
    end

    // One flop per register; pair port wins over the byte port
    genvar g;
    generate
        for (g = 0; g < `RFD_NREG; g++)
        begin : g_rf
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                    rf_ff[g] <= 8'h00;
                else if (pair_we && (pair_wa == 5'(g)))
                    rf_ff[g] <= pair_wd[7:0];
                else if (pair_we && (pair_wa + 5'h01 == 5'(g)))
                    rf_ff[g] <= pair_wd[15:8];
                else if (byte_we && (byte_wa == 5'(g)))
                    rf_ff[g] <= byte_wd;
            end
        end
    endgenerate

    // SRAM requests from loads, stores and pushes
    always_comb
    begin
        sram_req = 1'b0;
        sram_we = 1'b0;
        sram_addr = `RFD_SRAM_AW'(ea - `RFD_SRAM_BASE);
        sram_wdata = rf_ff[cmd_rd];
        if (state_ff == S_PUSH_LO || state_ff == S_PUSH_HI)
        begin
            sram_req = region(sp_ext) == RG_SRAM;
            sram_we = 1'b1;
            sram_addr = `RFD_SRAM_AW'(sp_ext - `RFD_SRAM_BASE);
            sram_wdata = (state_ff == S_PUSH_LO) ? ret_ff[7:0] : {2'b00, ret_ff[13:8]};
        end
        else if (take_cmd && (cmd_op == OP_LD || cmd_op == OP_ST) && reg_kind == RG_SRAM)
        begin
            sram_req = 1'b1;
            sram_we = cmd_op == OP_ST;
        end
    end

    rfd_sram u_sram (
        .clk(clk),
        .rst_n(rst_n),
        .req(sram_req),
        .we(sram_we),
        .addr(sram_addr),
        .wdata(sram_wdata),
        .rdata(sram_rdata)
    );

    // Next state and jump decision
    always_comb
    begin
        nxt_state = state_ff;
        jump = 1'b0;
        jump_tgt = cmd_addr[13:0];
        case (state_ff)
            S_EXEC:
            begin
                if (take_irq)
                begin
                    jump = 1'b1;
                    jump_tgt = 14'(irq_sel) * `RFD_VEC_WORDS;
                    nxt_state = S_PUSH_LO;
                end
                else if (take_cmd)
                begin
                    case (cmd_op)
                        OP_LD, OP_ST: nxt_state = (reg_kind == RG_SRAM ||
                            (reg_kind == RG_IO && ea < `RFD_SPL_ADDR)) ? S_WAIT : S_EXEC;
                        OP_LPM: nxt_state = S_LPM;
                        OP_JMP: jump = 1'b1;
                        OP_IJMP:
                        begin
                            jump = 1'b1;
                            jump_tgt = {rf_ff[`RFD_PTR_Z + 5'h01][5:0], rf_ff[`RFD_PTR_Z]};
                        end
                        OP_CALL:
                        begin
                            jump = 1'b1;
                            nxt_state = S_PUSH_LO;
                        end
                        default: nxt_state = S_EXEC;
                    endcase
                end
            end
            S_PUSH_LO: nxt_state = S_PUSH_HI;
            default: nxt_state = S_EXEC;
        endcase
    end

    // Sequencer state and handshake
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_ff <= S_EXEC;
            cmd_ready_ff <= 1'b0;
            irq_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
            irq_ff <= irq_req;
            cmd_ready_ff <= (nxt_state == S_EXEC) && !(sreg_ff[`RFD_SREG_GIE] && (|irq_req));
        end
    end

    // Single-stage prefetch; a taken jump drops the word in flight
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pmem_addr_ff <= `RFD_PC_RST;
            instr_ff <= 16'h0000;
            instr_valid_ff <= 1'b0;
            instr_pc_ff <= `RFD_PC_RST;
            resume_ff <= `RFD_PC_RST;
        end
        else
        begin
            instr_valid_ff <= 1'b0;
            if (jump)
                pmem_addr_ff <= jump_tgt;
            else if (take_cmd && cmd_op == OP_LPM)
            begin
                resume_ff <= pmem_addr_ff;
                pmem_addr_ff <= zword;
            end
            else if (state_ff == S_LPM)
                pmem_addr_ff <= resume_ff;
            else if (state_ff == S_EXEC && cmd_ready_ff && nxt_state == S_EXEC)
            begin
                instr_ff <= pmem_rdata;
                instr_pc_ff <= pmem_addr_ff;
                instr_valid_ff <= 1'b1;
                pmem_addr_ff <= pmem_addr_ff + 14'h0001;
            end
        end
    end

    // Pending load bookkeeping and return address
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ld_pend_ff <= 1'b0;
            ld_rd_ff <= 5'h00;
            ld_src_ff <= RG_NONE;
            ld_lsb_ff <= 1'b0;
            ld_blk_ff <= 1'b0;
            ret_ff <= `RFD_PC_RST;
        end
        else
        begin
            if (take_cmd)
            begin
                ld_pend_ff <= (cmd_op == OP_LD) || (cmd_op == OP_LPM);
                ld_rd_ff <= cmd_rd;
                ld_src_ff <= reg_kind;
                ld_lsb_ff <= rf_ff[`RFD_PTR_Z][0];
                ld_blk_ff <= (tgt_boot != from_boot) && (tgt_boot ?
                             boot_lock[`RFD_LOCK_RD] : app_lock[`RFD_LOCK_RD]);
                ret_ff <= pmem_addr_ff;
            end
            else if (take_irq)
                ret_ff <= instr_valid_ff ? instr_pc_ff : pmem_addr_ff;
            else if (nxt_state == S_EXEC)
                ld_pend_ff <= 1'b0;
        end
    end

    // Status, stack pointer and interrupt entry
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sreg_ff <= `RFD_SREG_RST;
            sp_ff <= `RFD_SP_RST;
            irq_ack_ff <= 1'b0;
            irq_idx_ff <= 3'd0;
        end
        else
        begin
            irq_ack_ff <= take_irq;
            if (take_irq)
            begin
                irq_idx_ff <= irq_sel;
                sreg_ff[`RFD_SREG_GIE] <= 1'b0;
            end
            if (state_ff == S_PUSH_LO || state_ff == S_PUSH_HI)
                sp_ff <= sp_ff - 12'h001;
            if (take_cmd && cmd_op == OP_ALU)
            begin
                sreg_ff[`RFD_SREG_Z] <= alu_res[7:0] == 8'h00;
                sreg_ff[`RFD_SREG_C] <= alu_res[8];
            end
            if (take_cmd && cmd_op == OP_ST)
            begin
                case (ea)
                    `RFD_SPL_ADDR: sp_ff[7:0] <= rf_ff[cmd_rd];
                    `RFD_SPH_ADDR: sp_ff[11:8] <= rf_ff[cmd_rd][3:0];
                    `RFD_SREG_ADDR: sreg_ff <= rf_ff[cmd_rd];
                    default: sp_ff <= sp_ff;
                endcase
            end
        end
    end

    // External I/O strobes and flash self-write
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            io_addr_ff <= 6'h00;
            io_wdata_ff <= 8'h00;
            io_we_ff <= 1'b0;
            io_re_ff <= 1'b0;
            flash_we_ff <= 1'b0;
            flash_waddr_ff <= 14'h0000;
            flash_wdata_ff <= 16'h0000;
        end
        else
        begin
            io_we_ff <= 1'b0;
            io_re_ff <= 1'b0;
            flash_we_ff <= 1'b0;
            if (take_cmd && reg_kind == RG_IO && ea < `RFD_SPL_ADDR)
            begin
                io_addr_ff <= 6'(ea - `RFD_IO_BASE);
                io_wdata_ff <= rf_ff[cmd_rd];
                io_we_ff <= cmd_op == OP_ST;
                io_re_ff <= cmd_op == OP_LD;
            end
            if (take_cmd && cmd_op == OP_SPM)
            begin
                flash_we_ff <= from_boot && !(tgt_boot ? boot_lock[`RFD_LOCK_WR]
                               : app_lock[`RFD_LOCK_WR]);
                flash_waddr_ff <= zword;
                flash_wdata_ff <= {rf_ff[1], rf_ff[0]};
            end
        end
    end
endmodule
`default_nettype wire

// File: hw/rfd_pkg.sv
// Types shared by the register file and data-space decode block
`default_nettype none
`include "rfd_cfg.svh"
package rfd_pkg;
    typedef enum logic [3:0] {OP_NOP, OP_ALU, OP_MUL, OP_LD, OP_ST, OP_LPM, OP_SPM,
                              OP_JMP, OP_CALL, OP_IJMP} rfd_op_e;
    typedef enum logic [2:0] {ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_EOR, ALU_MOV,
                              ALU_INC, ALU_DEC} rfd_alu_e;
    typedef enum logic [2:0] {AM_DIRECT, AM_DISP, AM_IND, AM_PREDEC, AM_POSTINC} rfd_amode_e;
    typedef enum logic [1:0] {PTR_X, PTR_Y, PTR_Z} rfd_ptr_e;
    typedef enum logic [1:0] {MUL_U, MUL_S, MUL_F} rfd_mul_e;
    typedef enum logic [1:0] {RG_REG, RG_IO, RG_SRAM, RG_NONE} rfd_region_e;
    // Gray codes along exec -> wait and push -> push -> exec; exec -> push flips two bits
    typedef enum logic [2:0] {S_EXEC = 3'b000, S_WAIT = 3'b001, S_PUSH_LO = 3'b011,
                              S_PUSH_HI = 3'b010, S_LPM = 3'b100} rfd_state_e;
endpackage
`default_nettype wire

// File: hw/rfd_sram.sv
// Internal data SRAM with a two-cycle access
`default_nettype none
`include "rfd_cfg.svh"
module rfd_sram (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic req,
    input wire logic we,
    input wire logic [`RFD_SRAM_AW-1:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);
    logic [7:0] mem [`RFD_SRAM_DEPTH]; // Byte array
    logic req_ff; // First cycle: request captured
    logic we_ff;
    logic [`RFD_SRAM_AW-1:0] addr_ff;
    logic [7:0] wdata_ff;

    // Cycle one latches the request
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            req_ff <= 1'b0;
            we_ff <= 1'b0;
            addr_ff <= '0;
            wdata_ff <= 8'h00;
        end
        else
        begin
            req_ff <= req;
            we_ff <= we;
            addr_ff <= addr;
            wdata_ff <= wdata;
        end
    end

    // Cycle two touches the array
    always_ff @(posedge clk)
    begin
        if (req_ff && we_ff)
        begin
            mem[addr_ff] <= wdata_ff;
        end
    end

    // Read data stands during the second cycle
    assign rdata = mem[addr_ff];
endmodule
`default_nettype wire
